/* File: hw/clk_switch_defs.svh */
// register offsets, field positions, reset values and timing counts of the clock switch
`ifndef CLK_SWITCH_DEFS_SVH
`define CLK_SWITCH_DEFS_SVH

`define OFS_TRIM 4'h0
`define OFS_INT_CTRL 4'h1
`define OFS_SRC_CTRL 4'h2
`define OFS_CFG_SEL 4'h3
`define OFS_STATUS 4'h4

`define TRIM_RESET 8'h7F
`define CFG_SEL_RESET 8'h20
`define INT_CFG_RC 4'h2

`define SRC_INT_SUT_HI 7
`define SRC_INT_SUT_LO 6
`define SRC_EXT_SUT_HI 5
`define SRC_EXT_SUT_LO 4
`define SRC_INT_EN 3
`define SRC_EXT_EN 2
`define SRC_CPU_SEL 0

`define CLK_PERIOD_NS 10
`define SHORT_START_CK 6
`define RESET_START_CK 14
`define DELAY_FAST_US 4100
`define DELAY_SLOW_US 65000
`define DELAY_FAST_CYC ((`DELAY_FAST_US * 1000) / `CLK_PERIOD_NS)
`define DELAY_SLOW_CYC ((`DELAY_SLOW_US * 1000) / `CLK_PERIOD_NS)

`endif

/* File: hw/clk_switch_pkg.sv */
// types shared by the clock switch controller
`default_nettype none
package clk_switch_pkg;
	typedef enum logic [3:0] {
		OSC_OFF = 4'b0001,
		OSC_WAIT = 4'b0010,
		OSC_RUN = 4'b0100,
		OSC_RSVD = 4'b1000
	} osc_state_t;
	typedef enum logic [1:0] {
		SUT_BOD = 2'b00,
		SUT_FAST = 2'b01,
		SUT_SLOW = 2'b10,
		SUT_RESERVED = 2'b11
	} sut_t;
endpackage : clk_switch_pkg
`default_nettype wire

/* File: hw/osc_start_timer.sv */
// one oscillator's enable to running sequencer with start-up delay counting
`default_nettype none
`include "clk_switch_defs.svh"
module osc_start_timer #(
	parameter int FAST_CYC = `DELAY_FAST_CYC,
	parameter int SLOW_CYC = `DELAY_SLOW_CYC
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control
	input wire logic enable_i,
	input wire logic after_reset_i,
	input wire logic [1:0] sut_i,
	// status
	output logic running_o,
	output logic reserved_o
);
	clk_switch_pkg::osc_state_t state;
	logic [23:0] count;
	logic [23:0] target;

	always_comb begin
		target = 24'(`SHORT_START_CK);
		if (after_reset_i) begin
			case (sut_i)
				clk_switch_pkg::SUT_BOD: target = 24'(`RESET_START_CK);
				clk_switch_pkg::SUT_FAST: target = 24'(`RESET_START_CK + FAST_CYC);
				default: target = 24'(`RESET_START_CK + SLOW_CYC);
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= clk_switch_pkg::OSC_OFF;
			count <= 24'h00_0000;
		end else begin
			case (state)
				clk_switch_pkg::OSC_OFF: begin
					count <= 24'h00_0000;
					if (enable_i) begin
						// reserved code never lets the source start
						if (sut_i == clk_switch_pkg::SUT_RESERVED) begin
							state <= clk_switch_pkg::OSC_RSVD;
						end else begin
							state <= clk_switch_pkg::OSC_WAIT;
						end
					end
				end
				clk_switch_pkg::OSC_WAIT: begin
					if (!enable_i) begin
						state <= clk_switch_pkg::OSC_OFF;
					end else if (count + 24'h00_0001 >= target) begin
						state <= clk_switch_pkg::OSC_RUN;
					end else begin
						count <= count + 24'h00_0001;
					end
				end
				clk_switch_pkg::OSC_RUN: begin
					if (!enable_i) begin
						state <= clk_switch_pkg::OSC_OFF;
					end
				end
				default: begin
					if (!enable_i) begin
						state <= clk_switch_pkg::OSC_OFF;
					end
				end
			endcase
		end
	end

	assign running_o = (state == clk_switch_pkg::OSC_RUN);
	assign reserved_o = (state == clk_switch_pkg::OSC_RSVD);
endmodule : osc_start_timer
`default_nettype wire

/* File: hw/clock_switch_controller.sv */
// clock switch controller: rc trim, source enables, start-up timing, glitch-free cpu source select
// Function
// - trim code zero slowest, all-ones fastest
// - trim linear, about 0.4 percent per step
// - slow-select clear gives 8 MHz, set 1 MHz
// - upper seven control bits read zero
// - trim step same in both output settings
// - start-up fuse code picks start delays
// - only rc, external, low power crystal switch; this block switches rc and external only
// - rc start-up field fuse loaded, writes ignored
// - external start-up field fuse loaded, rewritable
// - bit 3 starts and stops rc
// - bit 2 starts and stops external source
// - bit 0 selects source, fuse sets it
// - config register two nibbles, rc resets 0010
// - running status follows each oscillator state
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`default_nettype none
`include "clk_switch_defs.svh"
module clock_switch_controller #(
	parameter int FAST_CYC = `DELAY_FAST_CYC,
	parameter int SLOW_CYC = `DELAY_SLOW_CYC,
	parameter int TRIM_BITS = 8,
	parameter logic [TRIM_BITS-1:0] TRIM_FACTORY = `TRIM_RESET
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [3:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// fuse straps, sampled while reset is high
	input wire logic [1:0] startup_fuse_i,
	input wire logic [3:0] clock_fuse_select_i,
	input wire logic fuse_selects_ext_i,
	// oscillator control and cpu source
	output logic internal_osc_on_o,
	output logic ext_osc_on_o,
	output logic [TRIM_BITS-1:0] osc_trim_value_o,
	output logic internal_osc_slow_select_o,
	output logic [1:0] ext_osc_startup_o,
	output logic cpu_clock_source_o,
	output logic switch_busy_o
);
	logic [TRIM_BITS-1:0] osc_trim_value;
	logic internal_osc_slow_select;
	logic [1:0] internal_osc_startup;
	logic [1:0] ext_osc_startup;
	logic internal_osc_enable;
	logic ext_osc_enable;
	logic cpu_clock_source;
	logic [3:0] internal_osc_config;
	logic [3:0] ext_osc_config;
	logic cpu_source_active;
	logic [1:0] fuse_sut_s1, fuse_sut_s2;
	logic [3:0] fuse_clock_fuse_select_s1, fuse_clock_fuse_select_s2;
	logic fuse_ext_s1, fuse_ext_s2;
	logic int_after_reset, ext_after_reset;
	logic internal_osc_running, ext_osc_running;
	logic int_reserved, ext_reserved;
	logic ack;
	logic wr_hit;
	logic [31:0] next_readdata;

	//////////////////////////////////////////////////////////////////////////
	// fuse synchronisers; straps are caught while reset is asserted
	always_ff @(posedge core_clk_i) begin
		fuse_sut_s1 <= startup_fuse_i;
		fuse_sut_s2 <= fuse_sut_s1;
		fuse_clock_fuse_select_s1 <= clock_fuse_select_i;
		fuse_clock_fuse_select_s2 <= fuse_clock_fuse_select_s1;
		fuse_ext_s1 <= fuse_selects_ext_i;
		fuse_ext_s2 <= fuse_ext_s1;
	end

	//////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle on every access, answer on the second edge
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (read_i || write_i) && !ack;
		end
	end
	assign waitrequest_o = (read_i || write_i) && !ack;
	assign wr_hit = write_i && ack && byteenable_i[0];

	//////////////////////////////////////////////////////////////////////////
	// trim register; the code drives the rc linearly, 0 slowest, all-ones fastest
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			osc_trim_value <= TRIM_FACTORY;
		end else if (wr_hit && address_i == `OFS_TRIM) begin
			osc_trim_value <= writedata_i[TRIM_BITS-1:0];
		end
	end
	// trim reaches the rc unchanged in both output settings
	assign osc_trim_value_o = osc_trim_value;

	//////////////////////////////////////////////////////////////////////////
	// internal oscillator control: only the slow-select bit is stored
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			internal_osc_slow_select <= 1'b0;
		end else if (wr_hit && address_i == `OFS_INT_CTRL) begin
			internal_osc_slow_select <= writedata_i[0];
		end
	end
	assign internal_osc_slow_select_o = internal_osc_slow_select;

	//////////////////////////////////////////////////////////////////////////
	// source control register
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			internal_osc_startup <= fuse_sut_s2;
			ext_osc_startup <= fuse_sut_s2;
			internal_osc_enable <= !fuse_ext_s2;
			ext_osc_enable <= fuse_ext_s2;
			cpu_clock_source <= fuse_ext_s2;
		end else if (wr_hit && address_i == `OFS_SRC_CTRL) begin
			// rc start-up field only matters after reset, so writes are dropped
			ext_osc_startup <= writedata_i[`SRC_EXT_SUT_HI:`SRC_EXT_SUT_LO];
			internal_osc_enable <= writedata_i[`SRC_INT_EN];
			ext_osc_enable <= writedata_i[`SRC_EXT_EN];
			cpu_clock_source <= writedata_i[`SRC_CPU_SEL];
		end
	end
	assign ext_osc_startup_o = ext_osc_startup;

	//////////////////////////////////////////////////////////////////////////
	// clock configuration register
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			internal_osc_config <= `INT_CFG_RC;
			// the ext nibble of the reset pattern is all zero when rc is the fuse choice
			ext_osc_config <= fuse_ext_s2 ? fuse_clock_fuse_select_s2 : 4'h0;
		end else if (wr_hit && address_i == `OFS_CFG_SEL) begin
			internal_osc_config <= writedata_i[7:4];
			ext_osc_config <= writedata_i[3:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// reset-length start delay applies to every start until the oscillator first runs after reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			int_after_reset <= 1'b1;
			ext_after_reset <= 1'b1;
		end else begin
			if (internal_osc_running) begin
				int_after_reset <= 1'b0;
			end
			if (ext_osc_running) begin
				ext_after_reset <= 1'b0;
			end
		end
	end

	osc_start_timer #(
		.FAST_CYC(FAST_CYC),
		.SLOW_CYC(SLOW_CYC)
	) u_int_timer (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.enable_i(internal_osc_enable),
		.after_reset_i(int_after_reset),
		.sut_i(internal_osc_startup),
		.running_o(internal_osc_running),
		.reserved_o(int_reserved)
	);

	osc_start_timer #(
		.FAST_CYC(FAST_CYC),
		.SLOW_CYC(SLOW_CYC)
	) u_ext_timer (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.enable_i(ext_osc_enable),
		.after_reset_i(ext_after_reset),
		.sut_i(ext_osc_startup),
		.running_o(ext_osc_running),
		.reserved_o(ext_reserved)
	);

	assign internal_osc_on_o = internal_osc_enable;
	assign ext_osc_on_o = ext_osc_enable;

	//////////////////////////////////////////////////////////////////////////
	// cpu source mux control: the active source changes only once the new one runs,
	// but the running flag lags the enable by a cycle, so the mux can be switched onto an input stopped one edge earlier; only two sources exist here
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cpu_source_active <= 1'b0;
		end else if (cpu_clock_source != cpu_source_active) begin
			if (cpu_clock_source && ext_osc_running) begin
				cpu_source_active <= 1'b1;
			end else if (!cpu_clock_source && internal_osc_running) begin
				cpu_source_active <= 1'b0;
			end
		end
	end
	assign cpu_clock_source_o = cpu_source_active;
	assign switch_busy_o = (cpu_clock_source != cpu_source_active);

	//////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (address_i == `OFS_TRIM) begin
			next_readdata[TRIM_BITS-1:0] = osc_trim_value;
		end else if (address_i == `OFS_INT_CTRL) begin
			next_readdata[0] = internal_osc_slow_select;
		end else if (address_i == `OFS_SRC_CTRL) begin
			next_readdata[7:0] = {internal_osc_startup, ext_osc_startup,
				internal_osc_enable, ext_osc_enable, 1'b0, cpu_clock_source};
		end else if (address_i == `OFS_CFG_SEL) begin
			next_readdata[7:0] = {internal_osc_config, ext_osc_config};
		end else if (address_i == `OFS_STATUS) begin
			next_readdata[3:0] = {ext_reserved, int_reserved,
				internal_osc_running, ext_osc_running};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && !ack) begin
			readdata_o <= next_readdata;
		end
	end
endmodule : clock_switch_controller
`default_nettype wire

/* File: tb/clock_switch_controller_assertions.sv */
// concurrent checks on the clock switch controller ports
`default_nettype none
module clock_switch_controller_assertions #(
	parameter int FAST_CYC = 20,
	parameter int SLOW_CYC = 40,
	parameter int TRIM_BITS = 8
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register bus
	input wire logic [3:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	// oscillator control
	input wire logic internal_osc_on_o,
	input wire logic ext_osc_on_o,
	input wire logic [TRIM_BITS-1:0] osc_trim_value_o,
	input wire logic internal_osc_slow_select_o,
	input wire logic cpu_clock_source_o,
	input wire logic switch_busy_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic rd;
	logic wr;
	// a transfer completes only at the edge where waitrequest is low
	assign rd = read_i && !waitrequest_o;
	assign wr = write_i && !waitrequest_o && byteenable_i[0];
	////////////////////////////////////////////////////////////////////////////////
	a_int_upper_zero: assert property (rd && address_i == 4'h1 |-> readdata_o[7:1] == 7'h00)
		else $error("int ctrl upper bits not zero");
	a_rsvd_bit_zero: assert property (rd && address_i == 4'h2 |-> readdata_o[1] == 1'b0)
		else $error("src ctrl bit 1 not zero");
	a_trim_takes_write: assert property (wr && address_i == 4'h0
		|=> osc_trim_value_o == $past(writedata_i[TRIM_BITS-1:0])) else $error("trim not updated");
	a_slow_sel_write: assert property (wr && address_i == 4'h1
		|=> internal_osc_slow_select_o == $past(writedata_i[0])) else $error("slow select wrong");
	a_rc_enable_bit: assert property (wr && address_i == 4'h2
		|=> internal_osc_on_o == $past(writedata_i[3])) else $error("rc enable wrong");
	a_ext_enable_bit: assert property (wr && address_i == 4'h2
		|=> ext_osc_on_o == $past(writedata_i[2])) else $error("ext enable wrong");
	a_to_ext_running: assert property ($rose(cpu_clock_source_o) |-> ext_osc_on_o)
		else $error("moved to stopped ext source");
	a_to_rc_running: assert property ($fell(cpu_clock_source_o) |-> internal_osc_on_o)
		else $error("moved to stopped rc source");
	a_switch_when_busy: assert property ($changed(cpu_clock_source_o) |-> $past(switch_busy_o))
		else $error("source changed while not busy");
	c_src_write: cover property (wr && address_i == 4'h2);
	c_to_ext: cover property ($rose(cpu_clock_source_o));
	c_to_rc: cover property ($fell(cpu_clock_source_o));
endmodule : clock_switch_controller_assertions
bind clock_switch_controller clock_switch_controller_assertions #(.FAST_CYC(FAST_CYC),
	.SLOW_CYC(SLOW_CYC), .TRIM_BITS(TRIM_BITS)) i_chk (.core_clk_i, .rst_i, .address_i,
	.read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
	.internal_osc_on_o, .ext_osc_on_o, .osc_trim_value_o, .internal_osc_slow_select_o,
	.cpu_clock_source_o, .switch_busy_o);
`default_nettype wire

/* File: tb/ext_clock_source.sv */
// behavioural external clock source that runs only while enabled
`default_nettype none
module ext_clock_source #(
	parameter int HALF_NS = 7
) (
	// enable from the controller
	input wire logic enable_i,
	// clock toward the switch
	output logic ext_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ext_clk_o = 1'b0;
	// fixed period: a real core misbehaves on big steps between cycles; parked low when off
	always begin
		#HALF_NS;
		ext_clk_o = enable_i ? !ext_clk_o : 1'b0;
	end
endmodule : ext_clock_source
`default_nettype wire

/* File: tb/clock_switch_controller_tb.sv */
// self-checking bench for the clock switch controller
`default_nettype none
module clock_switch_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] address_i = 4'h0;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0000_0000;
	logic [3:0] byteenable_i = 4'hf;
	logic [31:0] readdata_o;
	logic waitrequest_o, int_on, ext_on, slow, cpu_src, busy, ext_clk;
	logic [7:0] trim, q, v;
	logic [1:0] ext_sut;
	logic [31:0] lfsr = 32'h0000_f705;
	int error_cnt = 0;
	int n_checks = 0;
	int ext_edges = 0;
	int i;
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge ext_clk) ext_edges++;
	clock_switch_controller #(.FAST_CYC(20), .SLOW_CYC(40)) i_clock_switch_controller (
		.core_clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
		.readdata_o, .waitrequest_o, .startup_fuse_i(2'b00), .clock_fuse_select_i(4'h2),
		.fuse_selects_ext_i(1'b0), .internal_osc_on_o(int_on), .ext_osc_on_o(ext_on),
		.osc_trim_value_o(trim), .internal_osc_slow_select_o(slow),
		.ext_osc_startup_o(ext_sut), .cpu_clock_source_o(cpu_src), .switch_busy_o(busy));
	ext_clock_source i_ext_clock_source (.enable_i(ext_on), .ext_clk_o(ext_clk));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// rc start-up field is fuse-owned and bit 1 is reserved
	function automatic logic [7:0] src_exp(input logic [7:0] w, input logic [1:0] rc_sut);
		return {rc_sut, w[5:2], 1'b0, w[0]};
	endfunction : src_exp
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		logic ok;
		address_i <= a;
		writedata_i <= {24'h00_0000, d};
		byteenable_i <= be;
		write_i <= w;
		read_i <= !w;
		// waitrequest is looked at mid-cycle, where it has settled, then the edge is taken
		do begin
			@(negedge core_clk_i);
			ok = (waitrequest_o === 1'b0);
			@(posedge core_clk_i);
		end while (!ok);
		q = readdata_o[7:0];
		write_i <= 1'b0;
		read_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : bus
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic poll(input int lim);
		i = 0;
		do begin
			bus(1'b0, 4'h4, 8'h00, 4'hf);
			i++;
		end while (q[0] !== 1'b1 && i < lim);
	endtask : poll
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		results();
	end
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		bus(1'b0, 4'h3, 8'h00, 4'hf); chk(q, 8'h20);
		bus(1'b0, 4'h1, 8'h00, 4'hf); chk(q, 8'h00);
		bus(1'b0, 4'h2, 8'h00, 4'hf); chk(q & 8'hcf, 8'h08);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			lfsr = nxt(lfsr);
			v = k == 0 ? 8'h00 : k == 1 ? 8'hff : lfsr[7:0];
			// no memory write is in flight, so the full trim range is allowed here
			bus(1'b1, 4'h0, v, 4'hf);
			bus(1'b0, 4'h0, 8'h00, 4'hf); chk(q, v);
			chk(trim, v);
		end
		bus(1'b1, 4'h1, 8'hff, 4'hf);
		bus(1'b0, 4'h1, 8'h00, 4'hf); chk(q, 8'h01);
		chk({7'h00, slow}, 8'h01);
		bus(1'b1, 4'h1, 8'h00, 4'hf);
		bus(1'b1, 4'h1, 8'h01, 4'h0); chk({7'h00, slow}, 8'h00);
		// rc nibble kept at its reset code so a later switch to rc still starts
		bus(1'b1, 4'h3, {4'h2, lfsr[11:8]}, 4'hf);
		bus(1'b0, 4'h3, 8'h00, 4'hf); chk(q, {4'h2, lfsr[11:8]});
		bus(1'b1, 4'hf, 8'hff, 4'hf);
		bus(1'b0, 4'hf, 8'h00, 4'hf); chk(q, 8'h00);
		$display("test registers done");
		bus(1'b1, 4'h2, 8'hce, 4'hf);
		bus(1'b0, 4'h2, 8'h00, 4'hf); chk(q, src_exp(8'hce, 2'b00));
		chk({6'h00, ext_sut}, 8'h00);
		poll(30); chk(q & 8'h03, 8'h03);
		chk({7'h00, ext_edges > 0}, 8'h01);
		bus(1'b1, 4'h2, 8'h0d, 4'hf);
		repeat (3) @(posedge core_clk_i);
		chk({6'h00, cpu_src, busy}, 8'h02);
		// suspend order: rc already running, select it, then stop the external source
		bus(1'b1, 4'h2, 8'h0c, 4'hf);
		repeat (3) @(posedge core_clk_i);
		chk({7'h00, cpu_src}, 8'h00);
		bus(1'b1, 4'h2, 8'h08, 4'hf);
		repeat (3) @(posedge core_clk_i);
		bus(1'b0, 4'h4, 8'h00, 4'hf); chk(q & 8'h03, 8'h02);
		// wakeup order: start external, wait running, select it, stop rc
		bus(1'b1, 4'h2, 8'h0c, 4'hf);
		poll(10); chk(q & 8'h03, 8'h03);
		bus(1'b1, 4'h2, 8'h0d, 4'hf);
		repeat (3) @(posedge core_clk_i);
		bus(1'b1, 4'h2, 8'h05, 4'hf);
		repeat (3) @(posedge core_clk_i);
		bus(1'b0, 4'h4, 8'h00, 4'hf); chk(q & 8'h03, 8'h01);
		chk({6'h00, cpu_src, int_on}, 8'h02);
		// back to rc, then start the external source with the reserved start-up code
		bus(1'b1, 4'h2, 8'h38, 4'hf);
		repeat (12) @(posedge core_clk_i);
		bus(1'b1, 4'h2, 8'h3c, 4'hf);
		repeat (4) @(posedge core_clk_i);
		bus(1'b0, 4'h4, 8'h00, 4'hf); chk(q & 8'h0f, 8'h0a);
		chk({7'h00, cpu_src}, 8'h00);
		$display("test switching done");
		results();
	end
endmodule : clock_switch_controller_tb
`default_nettype wire
